// File: hdl/retstack_unit.sv
// Return-stack push, pop and relative call unit of the processor core.
`default_nettype none
// Summary of operation
// RULE1: Push opcode puts PC plus two on stack top, flags untouched.
// RULE2: A push moves the old top one level deeper.
// RULE3: Software may rewrite the top entry and then push it.
// RULE4: Relative call decoded from top five bits 11011; eleven-bit signed offset.
// RULE5: Relative call pushes PC plus two before the PC changes.
// RULE6: Call target is incremented PC plus twice the signed offset.
// RULE7: Relative call takes two cycles; second cycle is a no-operation.
// RULE8: After pop the entry below becomes top; PC unaffected.
// RULE9: Pop discards the top in one cycle, flags untouched.
// RULE10: Push happens in quarter two; quarters three and four idle.
module retstack_unit
  import retstack_pkg::*;
(
  input wire logic CLK, // Core clock.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic [15:0] INSTR, // Instruction word being executed.
  input wire logic [PC_W-1:0] PC_IN, // Incremented program counter (PC+2).
  input wire logic TOP_WR, // Software write of the stack top entry.
  input wire logic [PC_W-1:0] TOP_WDATA, // Data for the stack top write.
  output logic [PC_W-1:0] STACK_TOP_ENTRY, // Current stack top entry.
  output logic [PTR_W-1:0] DEPTH_OUT, // Number of entries held.
  output logic [1:0] QUARTER, // Current quarter-cycle.
  output logic PC_LOAD, // Load PC from PC_TARGET, one-cycle pulse.
  output logic [PC_W-1:0] PC_TARGET, // New program counter for calls.
  output logic FLUSH // Second call cycle executes as no-operation.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // State.
  typedef enum logic [0:0] {EXEC, REFILL} cyc_e;
  cyc_e cyc_q, cyc_d;
  logic [1:0] q_q, q_d;
  logic [PC_W-1:0] mem_q [DEPTH];
  logic [PC_W-1:0] mem_d [DEPTH];
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic load_q, load_d;
  logic [PC_W-1:0] tgt_q, tgt_d;
  logic is_push, is_pop, is_call, is_stack_op;
  logic [PC_W-1:0] offs_ext;

  // Decode of the three instructions.
  assign is_push = (INSTR == OPC_PUSH) && cyc_q == EXEC; // RULE1
  assign is_pop = (INSTR == OPC_POP) && cyc_q == EXEC; // RULE9
  assign is_call = (INSTR[15:11] == OPC_RELATIVE_CALL_OP_HI) && cyc_q == EXEC; // RULE4
  assign is_stack_op = is_push || is_call;
  // Word offset sign-extended and doubled to a byte offset.
  assign offs_ext = {{(PC_W-OFFSET_W-1){INSTR[10]}}, INSTR[10:0], 1'b0};

  // ==========================================================
  // Sequencer: the quarter count wraps every four clocks, and a call
  // turns the next instruction cycle into a refill no-operation.
  always_comb
  begin
    q_d = q_q + 2'h1;
    cyc_d = cyc_q;
    if (q_q == Q_LAST)
    begin
      // Only the call lasts two cycles; every other opcode stays in EXEC.
      if (is_call)
        cyc_d = REFILL; // RULE7
      else
        cyc_d = EXEC;
    end
  end

  // Sequencer registers.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      q_q <= Q_DECODE;
      cyc_q <= EXEC;
    end
    else
    begin
      q_q <= q_d;
      cyc_q <= cyc_d;
    end
  end

  // ==========================================================
  // Stack: push and call write in quarter two, pop shifts up in quarter
  // three, and a software write of the top entry fills any other clock of a cycle that is not a push or call, except quarter three of a pop.
  // A push at full depth drops the deepest entry, and a pop on an empty
  // stack keeps the count at zero, so the count never wraps.
  always_comb
  begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    if (q_q == Q_STACK && is_stack_op)
    begin
      // Shift all entries down one level; the new one goes on top.
      for (int i = DEPTH - 1; i > 0; i--)
        mem_d[i] = mem_q[i-1]; // RULE2
      mem_d[0] = PC_IN; // RULE1 RULE5 RULE10
      if (ptr_q != PTR_W'(DEPTH))
        ptr_d = ptr_q + 5'h01;
    end
    else if (q_q == Q_POP && is_pop)
    begin
      // Shift all entries up one level; the bottom refills with zero.
      for (int i = 0; i < DEPTH - 1; i++)
        mem_d[i] = mem_q[i+1]; // RULE8
      mem_d[DEPTH-1] = PC_RESET;
      if (ptr_q != PTR_RESET)
        ptr_d = ptr_q - 5'h01; // RULE9
    end
    // A write is dropped for the whole of a push or call, so the pushed
    // entry never mixes an old and a new top.
    else if (TOP_WR && !is_stack_op)
      mem_d[0] = TOP_WDATA; // RULE3
  end

  // Stack registers; reset empties every level.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ptr_q <= PTR_RESET;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= PC_RESET;
    end
    else
    begin
      ptr_q <= ptr_d;
      mem_q <= mem_d;
    end
  end

  // ==========================================================
  // Call target: formed in the last quarter, after the return address is
  // already on the stack, and offered to the PC for exactly one clock.
  always_comb
  begin
    load_d = 1'b0;
    tgt_d = tgt_q;
    if (q_q == Q_PCWRITE && is_call)
    begin
      load_d = 1'b1; // RULE5
      tgt_d = PC_IN + offs_ext; // RULE6
    end
  end

  // Call target registers; the target holds until the next call.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      load_q <= 1'b0;
      tgt_q <= PC_RESET;
    end
    else
    begin
      load_q <= load_d;
      tgt_q <= tgt_d;
    end
  end

  // Outputs straight from flip-flops.
  assign STACK_TOP_ENTRY = mem_q[0];
  assign DEPTH_OUT = ptr_q;
  assign QUARTER = q_q;
  assign PC_LOAD = load_q;
  assign PC_TARGET = tgt_q;
  assign FLUSH = (cyc_q == REFILL);

  // ==========================================================
  // Assertions.
  a_push_top_value: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_STACK && is_push) |=> STACK_TOP_ENTRY == $past(PC_IN)) // RULE1
    else $error("Push did not place PC plus two on top.");
  a_push_shift_down: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_STACK && is_stack_op) |=> mem_q[1] == $past(mem_q[0])) // RULE2
    else $error("Old top not moved one level deeper.");
  a_top_write: assert property (@(posedge CLK) disable iff (RST)
    (TOP_WR && !is_stack_op && !(q_q == Q_POP && is_pop))
    |=> STACK_TOP_ENTRY == $past(TOP_WDATA)) // RULE3
    else $error("Top entry write lost.");
  a_call_decode: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_PCWRITE && is_call) |=> PC_LOAD) // RULE4
    else $error("Relative call not decoded.");
  a_call_push_first: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_STACK && is_call) |=> !PC_LOAD ##2 PC_LOAD) // RULE5
    else $error("Call pushed after PC update.");
  a_call_target: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_PCWRITE && is_call)
    |=> PC_TARGET == $past(PC_IN) + $past(offs_ext)) // RULE6
    else $error("Call target wrong.");
  a_call_refill: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_LAST && is_call) |=> FLUSH [*4] ##1 !FLUSH) // RULE7
    else $error("Call second cycle not four quarters.");
  a_pop_top: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_POP && is_pop) |=> STACK_TOP_ENTRY == $past(mem_q[1])) // RULE8
    else $error("Pop did not expose entry below.");
  a_pop_no_pc: assert property (@(posedge CLK) disable iff (RST)
    (is_pop && !is_call) |=> !PC_LOAD) // RULE9
    else $error("Pop changed the program counter.");
  a_push_quarter: assert property (@(posedge CLK) disable iff (RST)
    (ptr_q != $past(ptr_q) && ptr_q > $past(ptr_q))
    |-> $past(q_q) == Q_STACK) // RULE10
    else $error("Push outside quarter two.");
  a_push_depth: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_STACK && is_push && ptr_q != PTR_W'(DEPTH))
    |=> DEPTH_OUT == $past(ptr_q) + 5'h01) // RULE1
    else $error("Push did not add one entry.");
  a_pop_quarter: assert property (@(posedge CLK) disable iff (RST)
    (ptr_q < $past(ptr_q)) |-> $past(q_q) == Q_POP) // RULE9
    else $error("Pop outside quarter three.");
  a_pop_empty: assert property (@(posedge CLK) disable iff (RST)
    (q_q == Q_POP && is_pop && ptr_q == PTR_RESET)
    |=> DEPTH_OUT == PTR_RESET) // RULE9
    else $error("Pop on empty stack changed depth.");
  a_load_pulse: assert property (@(posedge CLK) disable iff (RST)
    PC_LOAD |=> !PC_LOAD) // RULE7
    else $error("PC load longer than one clock.");
  a_refill_idle: assert property (@(posedge CLK) disable iff (RST)
    FLUSH |=> DEPTH_OUT == $past(DEPTH_OUT)) // RULE7
    else $error("Stack moved during refill cycle.");
  a_pop_pc_kept: assert property (@(posedge CLK) disable iff (RST)
    is_pop |=> $stable(PC_TARGET)) // RULE8
    else $error("Pop moved the call target.");
  c_push: cover property (@(posedge CLK) q_q == Q_STACK && is_push);
  c_pop: cover property (@(posedge CLK) q_q == Q_POP && is_pop);
  c_call: cover property (@(posedge CLK) PC_LOAD ##1 FLUSH);
  c_top_write: cover property (@(posedge CLK) TOP_WR && !is_stack_op);
  c_pop_empty: cover property (@(posedge CLK)
    q_q == Q_POP && is_pop && ptr_q == PTR_RESET);
endmodule
`default_nettype wire

// File: hdl/retstack_pkg.sv
// Package of opcodes, widths and timing for the return-stack instruction unit.
`default_nettype none
package retstack_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Widths and depths.
  localparam int PC_W = 21;
  localparam int DEPTH = 31;
  localparam int PTR_W = 5;
  localparam int OFFSET_W = 11;
  // ==========================================================
  // Opcodes.
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [4:0] OPC_RELATIVE_CALL_OP_HI = 5'h1b;
  // ==========================================================
  // Timing and reset values.
  localparam int CLK_NS = 50;
  localparam int QUARTERS = 4;
  localparam logic [1:0] Q_LAST = 2'(QUARTERS - 1);
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_STACK = 2'h1;
  localparam logic [1:0] Q_POP = 2'h2;
  localparam logic [1:0] Q_PCWRITE = 2'h3;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
endpackage
`default_nettype wire

// File: verif/testbench.sv
// Self-checking testbench for the return-stack instruction unit.
`default_nettype none
module testbench
  import retstack_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic [PC_W-1:0] pc = '0;
  logic top_wr = 1'b0;
  logic [PC_W-1:0] top_wdata = '0;
  logic [PC_W-1:0] top;
  logic [PTR_W-1:0] depth;
  logic [1:0] quarter;
  logic pc_load;
  logic [PC_W-1:0] target;
  logic flush;
  int bad_count = 0;
  int cmp_count = 0;
  retstack_unit i_retstack_unit (.CLK(clk), .RST(rst), .INSTR(instr),
    .PC_IN(pc), .TOP_WR(top_wr), .TOP_WDATA(top_wdata),
    .STACK_TOP_ENTRY(top), .DEPTH_OUT(depth), .QUARTER(quarter),
    .PC_LOAD(pc_load), .PC_TARGET(target), .FLUSH(flush));
  // ==========================================================
  // Clock generator.
  always #(CLK_NS / 2) clk = ~clk;
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] e);
    cmp_count++;
    if (got !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Runs one instruction cycle from quarter zero, then returns to idle.
  task automatic run(input logic [15:0] op, input logic [PC_W-1:0] p);
    int n;
    n = 0;
    while (quarter !== Q_DECODE && n < 8)
    begin
      @(posedge clk);
      #5;
      n++;
    end
    if (quarter !== Q_DECODE)
      bad_count++;
    instr = op;
    pc = p;
    repeat (QUARTERS) @(posedge clk);
    #5;
    instr = 16'h0000;
  endtask
  // Two pushes back to back, then a pop.
  task automatic push_pop();
    run(OPC_PUSH, 21'h000126);
    chk(top, 21'h000126);
    chk(21'(depth), 21'h000001);
    chk(21'(quarter), 21'(Q_DECODE));
    run(OPC_PUSH, 21'h000200);
    chk(top, 21'h000200);
    run(OPC_POP, 21'h000300);
    chk(top, 21'h000126);
    chk(21'(depth), 21'h000001);
    chk(21'(pc_load), 21'h000000);
  endtask
  // Software rewrites the top entry, pushes over it and pops back.
  task automatic soft_stack();
    top_wr = 1'b1;
    top_wdata = 21'h00345a;
    @(posedge clk);
    #5;
    top_wr = 1'b0;
    chk(top, 21'h00345a);
    run(OPC_PUSH, 21'h000400);
    chk(top, 21'h000400);
    run(OPC_POP, 21'h000500);
    chk(top, 21'h00345a);
  endtask
  // Relative call with the given offset, checked across both cycles.
  task automatic call(input logic [10:0] off, input logic [PC_W-1:0] p);
    logic [PC_W-1:0] e;
    e = p + {{9{off[10]}}, off, 1'b0};
    run({OPC_RELATIVE_CALL_OP_HI, off}, p);
    chk(top, p);
    chk(21'(pc_load), 21'h000001);
    chk(target, e);
    chk(21'(flush), 21'h000001);
    @(posedge clk);
    #5;
    chk(21'(pc_load), 21'h000000);
    repeat (3) @(posedge clk);
    #5;
    chk(21'(flush), 21'h000000);
  endtask
  // Reset in mid-run, then a push timed quarter by quarter.
  task automatic reset_push();
    rst = 1'b1;
    @(posedge clk);
    #5;
    chk(21'(quarter), 21'(Q_DECODE));
    chk(21'(flush), 21'h000000);
    chk(21'(depth), 21'(PTR_RESET));
    rst = 1'b0;
    instr = OPC_PUSH;
    pc = 21'h000600;
    @(posedge clk);
    #5;
    chk(top, PC_RESET);
    @(posedge clk);
    #5;
    chk(top, 21'h000600);
    chk(21'(quarter), 21'(Q_POP));
    repeat (2) @(posedge clk);
    #5;
    instr = 16'h0000;
    chk(21'(depth), 21'h000001);
  endtask
  // Pops down to an empty stack and once more past it.
  task automatic pop_empty();
    run(OPC_POP, 21'h000700);
    chk(21'(depth), 21'h000000);
    run(OPC_POP, 21'h000700);
    chk(21'(depth), 21'h000000);
    chk(top, PC_RESET);
  endtask
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk);
    #5;
    rst = 1'b0;
    push_pop();
    soft_stack();
    call(11'h3ff, 21'h001000);
    call(11'h400, 21'h001000);
    call(11'h7ff, 21'h000010);
    run(16'hd7ff, 21'h000500);
    chk(top, 21'h000010);
    chk(21'(depth), 21'h000004);
    reset_push();
    pop_empty();
    results();
  end
  // Watchdog against a hang.
  initial
  begin
    #(CLK_NS * 1000);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
